// ===== logic/pat_objects.v
// explicit-message object block: parameter enabling, scale encoder, one-touch tuning
// assumes requests one cycle wide, synchronous to clk; tuning engine outside
//
// Function
// - apply pending parameters on network disconnection
// - apply pending parameters when leaving run mode
// - key write to 2D34h starts parameter apply
// - apply processing finishes within about 100 ms
// - apply object reads 0 busy, 1 idle
// - read-only scale resolution, cycle, whole-period objects
// - tuning mode 1-3 starts tuning, 0 stopped
// - tuning mode returns to 0 at finish
// - progress in percent, 100 at completion
// - stop key to 2D52h aborts tuning
// - other stop values answer status 09h
// - clear 0 restores initial, 1 previous values
// - clear also saves restored values nonvolatile
// - result object reports one tuning result code
// - nonvolatile save only on explicit store request or after a clear
`timescale 1ns/100ps
`include "pat_defines.vh"
module pat_objects #(
  parameter APPLY_CYCLES = `PAT_CLK_HZ / 1000 * `PAT_APPLY_MS,
  parameter TWIDTH = 23
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // object request from the network side
  input wire req_valid,
  input wire req_write,
  input wire [15:0] req_inst,
  input wire [31:0] req_wdata,
  // object answer
  output reg rsp_valid_r,
  output reg [7:0] rsp_status_r,
  output reg [31:0] rsp_rdata_r,
  // connection state
  input wire io_run_mode,
  input wire net_wait_connect,
  // scale encoder values
  input wire [31:0] scale_encoder_state,
  input wire [31:0] scale_cycle_count,
  input wire [31:0] scale_whole_period_count,
  input wire [31:0] scale_resolution,
  input wire [31:0] scale_encoder_fault,
  // parameter store
  output reg param_apply_r,
  output reg param_apply_busy_r,
  input wire store_request,
  output reg nonvolatile_store_r,
  // tuning engine
  output reg [7:0] tune_mode_r,
  output reg tune_start_r,
  output reg tune_abort_r,
  output reg tune_revert_initial_r,
  output reg tune_revert_before_r,
  input wire [7:0] tune_progress,
  input wire tune_done,
  input wire [15:0] tune_result
);
  localparam ST_IDLE = 3'b001;
  localparam ST_TUNE = 3'b010;
  localparam ST_REVERT = 3'b100;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg run_d_r;
  reg wait_d_r;
  reg [7:0] prog_r;
  reg [15:0] result_r;
  reg apply_go;
  reg [7:0] status_nxt;
  reg [31:0] rdata_nxt;
  wire timer_busy;
  wire wr;
  wire run_exit;
  wire net_drop;
  wire [7:0] wmode;
  wire [15:0] wkey;
  wire tune_go;
  wire revert_go;

  assign wr = req_valid & req_write;
  assign wmode = req_wdata[7:0];
  assign wkey = req_wdata[15:0];
  assign run_exit = run_d_r & ~io_run_mode;
  assign net_drop = net_wait_connect & ~wait_d_r;

  // accepted start and clear writes; status already refuses them unless idle
  assign tune_go = wr && req_inst == `PAT_OBJ_TUNE_CMD && status_nxt == `PAT_ST_OK &&
    wmode != `PAT_MODE_STOP;
  assign revert_go = wr && req_inst == `PAT_OBJ_TUNE_REVERT && status_nxt == `PAT_ST_OK;

  pat_timer #(
    .WIDTH(TWIDTH),
    .COUNT(APPLY_CYCLES[TWIDTH-1:0])
  ) u_apply_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(apply_go),
    .busy_r(timer_busy)
  );

  // answer status and apply trigger
  always @*
  begin
    status_nxt = `PAT_ST_OK;
    apply_go = 1'b0;
    if (run_exit || net_drop)
      apply_go = 1'b1;
    if (req_valid)
    begin
      case (req_inst)
        `PAT_OBJ_APPLY:
        begin
          if (!req_write)
            status_nxt = `PAT_ST_OK;
          else if (io_run_mode)
            status_nxt = `PAT_ST_BAD_STATE;
          else if (wkey != `PAT_KEY)
            status_nxt = `PAT_ST_BAD_VALUE;
          else
            apply_go = 1'b1;
        end
        `PAT_OBJ_ENC_STATE, `PAT_OBJ_CYCLE, `PAT_OBJ_WHOLE, `PAT_OBJ_RES,
        `PAT_OBJ_ENC_FAULT, `PAT_OBJ_TUNE_PROG, `PAT_OBJ_TUNE_RESULT:
        begin
          if (req_write)
            status_nxt = `PAT_ST_NOT_SET;
        end
        `PAT_OBJ_TUNE_CMD:
        begin
          if (!req_write)
            status_nxt = `PAT_ST_OK;
          else if (wmode > `PAT_MODE_LOW)
            status_nxt = `PAT_ST_BAD_VALUE;
          else if (state_r != ST_IDLE && wmode != `PAT_MODE_STOP)
            status_nxt = `PAT_ST_BAD_STATE;
        end
        `PAT_OBJ_TUNE_ABORT:
        begin
          if (!req_write)
            status_nxt = `PAT_ST_NOT_GET;
          else if (wkey != `PAT_KEY)
            status_nxt = `PAT_ST_BAD_VALUE;
        end
        `PAT_OBJ_TUNE_REVERT:
        begin
          if (!req_write)
            status_nxt = `PAT_ST_NOT_GET;
          else if (wkey != `PAT_REVERT_INITIAL && wkey != `PAT_REVERT_BEFORE)
            status_nxt = `PAT_ST_BAD_VALUE;
          else if (state_r != ST_IDLE)
            status_nxt = `PAT_ST_BAD_STATE;
        end
        default: status_nxt = `PAT_ST_NO_OBJECT;
      endcase
    end
  end

  // read data; refused reads and all writes answer zero
  // busy read follows the busy output so both agree at the end of a run
  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    if (req_valid && !req_write)
    begin
      case (req_inst)
        `PAT_OBJ_APPLY: rdata_nxt = {31'h0000_0000, ~param_apply_busy_r};
        `PAT_OBJ_ENC_STATE: rdata_nxt = scale_encoder_state;
        `PAT_OBJ_CYCLE: rdata_nxt = scale_cycle_count;
        `PAT_OBJ_WHOLE: rdata_nxt = scale_whole_period_count;
        `PAT_OBJ_RES: rdata_nxt = scale_resolution;
        `PAT_OBJ_ENC_FAULT: rdata_nxt = scale_encoder_fault;
        `PAT_OBJ_TUNE_CMD: rdata_nxt = {24'h00_0000, tune_mode_r};
        `PAT_OBJ_TUNE_PROG: rdata_nxt = {24'h00_0000, prog_r};
        `PAT_OBJ_TUNE_RESULT: rdata_nxt = {16'h0000, result_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // tuning sequence
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (tune_go)
          state_nxt = ST_TUNE;
        else if (revert_go)
          state_nxt = ST_REVERT;
      end
      ST_TUNE:
      begin
        if (tune_done)
          state_nxt = ST_IDLE;
      end
      ST_REVERT: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // connection edge detectors; both inputs idle low, so no edge after reset
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_d_r <= 1'b0;
      wait_d_r <= 1'b0;
    end
    else
    begin
      run_d_r <= io_run_mode;
      wait_d_r <= net_wait_connect;
    end
  end

  // object answer, one cycle after the request
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_valid_r <= 1'b0;
      rsp_status_r <= `PAT_ST_OK;
      rsp_rdata_r <= 32'h0000_0000;
    end
    else
    begin
      rsp_valid_r <= req_valid;
      rsp_status_r <= status_nxt;
      rsp_rdata_r <= rdata_nxt;
    end
  end

  // apply pulse and busy level; a new trigger restarts the bound
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      param_apply_r <= 1'b0;
      param_apply_busy_r <= 1'b0;
    end
    else
    begin
      param_apply_r <= apply_go;
      param_apply_busy_r <= timer_busy | apply_go;
    end
  end

  // save only after a clear or on an explicit store request
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      nonvolatile_store_r <= 1'b0;
    else if (state_r == ST_REVERT)
      nonvolatile_store_r <= 1'b1;
    else
      nonvolatile_store_r <= req_valid & store_request;
  end

  // one-hot tuning state
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // tuning mode object
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tune_mode_r <= `PAT_MODE_STOP;
    else if (state_r == ST_IDLE && state_nxt == ST_TUNE)
      tune_mode_r <= wmode;
    else if (state_r == ST_TUNE && tune_done)
      tune_mode_r <= `PAT_MODE_STOP;
  end

  // start pulse to the tuning engine
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tune_start_r <= 1'b0;
    else
      tune_start_r <= (state_r == ST_IDLE) & (state_nxt == ST_TUNE);
  end

  // progress and result objects; completion forces 100 percent
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prog_r <= 8'h00;
      result_r <= `PAT_RES_OK;
    end
    else if (state_r == ST_IDLE && state_nxt == ST_TUNE)
    begin
      prog_r <= 8'h00;
      result_r <= `PAT_RES_OK;
    end
    else if (state_r == ST_TUNE && tune_done)
    begin
      prog_r <= `PAT_PROG_DONE;
      result_r <= tune_result;
    end
    else if (state_r == ST_TUNE)
      prog_r <= tune_progress;
  end

  // abort pulse; a stop that meets the engine's own finish is dropped
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tune_abort_r <= 1'b0;
    else
      tune_abort_r <= (state_r == ST_TUNE) & ~tune_done & wr & (status_nxt == `PAT_ST_OK) &
        ((req_inst == `PAT_OBJ_TUNE_ABORT) |
        ((req_inst == `PAT_OBJ_TUNE_CMD) & (wmode == `PAT_MODE_STOP)));
  end

  // revert pulses, one per accepted clear write
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tune_revert_initial_r <= 1'b0;
      tune_revert_before_r <= 1'b0;
    end
    else
    begin
      tune_revert_initial_r <= (state_r == ST_IDLE) & (state_nxt == ST_REVERT) &
        (wkey == `PAT_REVERT_INITIAL);
      tune_revert_before_r <= (state_r == ST_IDLE) & (state_nxt == ST_REVERT) &
        (wkey == `PAT_REVERT_BEFORE);
    end
  end
endmodule // pat_objects

// ===== logic/pat_defines.vh
// constants for the parameter enabling and one-touch tuning object block
// included by the object block only; its timer module takes its count as a parameter
`ifndef PAT_DEFINES_VH
`define PAT_DEFINES_VH
// object instance numbers
`define PAT_OBJ_APPLY 16'h2D34
`define PAT_OBJ_ENC_STATE 16'h2D35
`define PAT_OBJ_CYCLE 16'h2D36
`define PAT_OBJ_WHOLE 16'h2D37
`define PAT_OBJ_RES 16'h2D38
`define PAT_OBJ_ENC_FAULT 16'h2D3C
`define PAT_OBJ_TUNE_CMD 16'h2D50
`define PAT_OBJ_TUNE_PROG 16'h2D51
`define PAT_OBJ_TUNE_ABORT 16'h2D52
`define PAT_OBJ_TUNE_REVERT 16'h2D53
`define PAT_OBJ_TUNE_RESULT 16'h2D54
// key values
`define PAT_KEY 16'h1EA5
`define PAT_REVERT_INITIAL 16'h0000
`define PAT_REVERT_BEFORE 16'h0001
// tuning modes and completed progress
`define PAT_MODE_STOP 8'h00
`define PAT_MODE_BASIC 8'h01
`define PAT_MODE_LOW 8'h03
`define PAT_PROG_DONE 8'h64
// result codes
`define PAT_RES_OK 16'h0000
`define PAT_RES_CANCEL 16'hC000
`define PAT_RES_OVERSHOOT 16'hC001
`define PAT_RES_SERVO_OFF 16'hC002
`define PAT_RES_CTRL_MODE 16'hC003
`define PAT_RES_TIMEOUT 16'hC004
`define PAT_RES_INERTIA 16'hC005
`define PAT_RES_DISABLED 16'hC00F
// answer status codes
`define PAT_ST_OK 8'h00
`define PAT_ST_BAD_VALUE 8'h09
`define PAT_ST_BAD_STATE 8'h0C
`define PAT_ST_NO_OBJECT 8'h16
`define PAT_ST_NOT_SET 8'h0E
`define PAT_ST_NOT_GET 8'h2C
// timing
`define PAT_CLK_HZ 40000000
`define PAT_APPLY_MS 100
`endif

// ===== logic/pat_timer.v
// one-shot down counter used to bound the parameter enabling processing
// assumes a single clock and an asynchronous active-low reset
`timescale 1ns/100ps
module pat_timer #(
  parameter WIDTH = 23,
  parameter [WIDTH-1:0] COUNT = 4000000
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control
  input wire start,
  output reg busy_r
);
  reg [WIDTH-1:0] cnt_r;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= {WIDTH{1'b0}};
      busy_r <= 1'b0;
    end
    else if (start)
    begin
      cnt_r <= COUNT - {{(WIDTH-1){1'b0}}, 1'b1};
      busy_r <= 1'b1;
    end
    else if (busy_r)
    begin
      if (cnt_r == {WIDTH{1'b0}})
        busy_r <= 1'b0;
      else
        cnt_r <= cnt_r - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule // pat_timer

// ===== dv/pat_objects_chk.sv
// checker for the object block ports
// bound to pat_objects below; apply count follows the instance
`timescale 1ns/100ps
module pat_objects_chk #(
  parameter APPLY_CYCLES = 20
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // request and answer
  input wire req_valid,
  input wire req_write,
  input wire [15:0] req_inst,
  input wire [31:0] req_wdata,
  input wire [7:0] rsp_status_r,
  input wire [31:0] rsp_rdata_r,
  // state and pulses
  input wire io_run_mode,
  input wire param_apply_r,
  input wire param_apply_busy_r,
  input wire [7:0] tune_mode_r,
  input wire tune_revert_initial_r,
  input wire nonvolatile_store_r,
  input wire tune_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire wr = req_valid && req_write;
  wire ak = wr && req_inst == 16'h2D34 && req_wdata == 32'h1EA5;
  reg [31:0] busy_n_r;
  // length of the current apply run
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      busy_n_r <= 32'h0;
    else
      busy_n_r <= param_apply_busy_r ? busy_n_r + 32'h1 : 32'h0;
  a_apply_key_go: assert property (ak && !io_run_mode && !param_apply_busy_r
    |=> param_apply_r && rsp_status_r == 8'h00) else $error("apply not started");
  a_apply_run_refused: assert property (ak && io_run_mode
    |=> !param_apply_r && rsp_status_r == 8'h0C) else $error("apply in run taken");
  a_apply_time_bound: assert property (busy_n_r <= APPLY_CYCLES + 2)
    else $error("apply too long");
  a_apply_read_back: assert property (req_valid && !req_write && req_inst == 16'h2D34
    |=> rsp_rdata_r == {31'h0, !$past(param_apply_busy_r)}) else $error("apply read");
  a_tune_start_mode: assert property (wr && req_inst == 16'h2D50 && req_wdata != 0
    && req_wdata <= 32'h3 && tune_mode_r == 8'h00 && !tune_done
    |=> tune_mode_r == $past(req_wdata[7:0])) else $error("tuning not started");
  a_tune_end_zero: assert property (tune_done && tune_mode_r != 8'h00 && !req_valid
    |=> tune_mode_r == 8'h00) else $error("mode not cleared");
  a_stop_bad_value: assert property (wr && req_inst == 16'h2D52
    && req_wdata[15:0] != 16'h1EA5 |=> rsp_status_r == 8'h09) else $error("bad stop taken");
  a_revert_then_save: assert property (wr && req_inst == 16'h2D53
    && req_wdata == 0 && tune_mode_r == 8'h00
    |=> tune_revert_initial_r ##1 nonvolatile_store_r) else $error("revert or save");
  c_apply: cover property (param_apply_r);
  c_tune_end: cover property (tune_done && tune_mode_r != 8'h00);
  c_save: cover property (nonvolatile_store_r);
endmodule // pat_objects_chk
bind pat_objects pat_objects_chk #(.APPLY_CYCLES(APPLY_CYCLES)) chk_u (.clk, .rst_n,
  .req_valid, .req_write, .req_inst, .req_wdata, .rsp_status_r, .rsp_rdata_r, .io_run_mode,
  .param_apply_r, .param_apply_busy_r, .tune_mode_r, .tune_revert_initial_r,
  .nonvolatile_store_r, .tune_done);

// ===== dv/pat_master.sv
// network master model: one explicit object request at a time
// request made at the falling edge, answer taken at the next falling edge
`timescale 1ns/100ps
module pat_master (
  // clock
  input wire clk,
  // request
  output reg req_valid = 1'b0,
  output reg req_write = 1'b0,
  output reg [15:0] req_inst = 16'h0,
  output reg [31:0] req_wdata = 32'h0,
  // answer
  input wire rsp_valid_r,
  input wire [7:0] rsp_status_r,
  input wire [31:0] rsp_rdata_r
);
  // released lines show inverted values
  task acc(input w, input [15:0] i, input [31:0] v, output [7:0] s, output [31:0] d);
    @(negedge clk);
    {req_valid, req_write, req_inst, req_wdata} = {1'b1, w, i, v};
    @(negedge clk);
    s = rsp_valid_r ? rsp_status_r : 8'hFF;
    d = rsp_rdata_r;
    {req_valid, req_inst, req_wdata} = {1'b0, ~i, ~v};
  endtask
endmodule // pat_master

// ===== dv/param_enable_and_autotune_objects_tb_top.sv
// bench for the object block: apply, scale and tuning objects
// master model makes requests; bench drives the rest at the falling edge
`timescale 1ns/100ps
module param_enable_and_autotune_objects_tb_top;
  reg clk, rst_n, io_run_mode, net_wait_connect, tune_done, store_request;
  reg [7:0] tune_progress, s;
  reg [15:0] tune_result;
  reg [31:0] d, sc;
  reg [5:0] seen;
  integer mismatches, checked, i, n;
  wire req_valid, req_write, rsp_valid_r, param_apply_r, param_apply_busy_r;
  wire nonvolatile_store_r, tune_start_r, tune_abort_r, tune_revert_initial_r;
  wire tune_revert_before_r;
  wire [15:0] req_inst;
  wire [31:0] req_wdata, rsp_rdata_r;
  wire [7:0] rsp_status_r, tune_mode_r;
  pat_objects #(.APPLY_CYCLES(20), .TWIDTH(5)) dut_u (.clk, .rst_n, .req_valid, .req_write,
    .req_inst, .req_wdata, .rsp_valid_r, .rsp_status_r, .rsp_rdata_r, .io_run_mode,
    .net_wait_connect, .scale_encoder_state(sc ^ 32'h5), .scale_cycle_count(sc),
    .scale_whole_period_count(~sc), .scale_resolution({sc[27:0], 4'h0}),
    .scale_encoder_fault(sc + 32'h1), .param_apply_r, .param_apply_busy_r,
    .store_request, .nonvolatile_store_r, .tune_mode_r, .tune_start_r, .tune_abort_r,
    .tune_revert_initial_r, .tune_revert_before_r, .tune_progress, .tune_done, .tune_result);
  pat_master m_u (.clk, .req_valid, .req_write, .req_inst, .req_wdata, .rsp_valid_r,
    .rsp_status_r, .rsp_rdata_r);
  // pulses seen since the last clear
  always @(posedge clk)
    seen <= seen | {param_apply_r, tune_start_r, nonvolatile_store_r, tune_revert_before_r,
      tune_revert_initial_r, tune_abort_r};
  task report_and_stop(input integer extra);
    mismatches = mismatches + extra;
    if (mismatches == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    checked = checked + 1;
    if (g !== e)
    begin
      mismatches = mismatches + 1;
      $display("MISMATCH at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // reads compare data with v
  task xfer(input w, input [15:0] a, input [31:0] v, input [7:0] es);
    m_u.acc(w, a, v, s, d);
    chk(s, es);
    if (!w)
      chk(d, v);
  endtask
  task wait_idle;
    for (n = 0; param_apply_busy_r !== 1'b0; n = n + 1)
      if (n == 30)
        report_and_stop(1);
      else
        @(negedge clk);
  endtask
  task pulse_done(input [15:0] c);
    @(negedge clk);
    {tune_done, tune_result} = {1'b1, c};
    @(negedge clk);
    tune_done = 1'b0;
  endtask
  task t_apply;
    seen = 6'h00;
    xfer(1, 16'h2D34, 32'h1EA5, 8'h00);
    xfer(0, 16'h2D34, 32'h0, 8'h00);
    wait_idle;
    xfer(0, 16'h2D34, 32'h1, 8'h00);
    chk(seen, 6'h20);
  endtask
  task t_state;
    @(negedge clk);
    io_run_mode = 1'b1;
    xfer(1, 16'h2D34, 32'h1EA5, 8'h0C);
    xfer(0, 16'h2D34, 32'h1, 8'h00);
    @(negedge clk);
    io_run_mode = 1'b0;
    repeat (3) @(negedge clk);
    chk(param_apply_busy_r, 1'b1);
    wait_idle;
    net_wait_connect = 1'b1;
    repeat (3) @(negedge clk);
    chk(param_apply_busy_r, 1'b1);
    net_wait_connect = 1'b0;
    wait_idle;
  endtask
  task t_scale;
    xfer(0, 16'h2D36, sc, 8'h00);
    xfer(0, 16'h2D37, ~sc, 8'h00);
    xfer(0, 16'h2D38, {sc[27:0], 4'h0}, 8'h00);
    xfer(1, 16'h2D38, 32'h1, 8'h0E);
    xfer(0, 16'h2D35, sc ^ 32'h5, 8'h00);
    xfer(0, 16'h2D3C, sc + 32'h1, 8'h00);
    xfer(0, 16'h2D52, 32'h0, 8'h2C);
    xfer(1, 16'h2D40, 32'h0, 8'h16);
    seen = 6'h00;
    store_request = 1'b1;
    xfer(0, 16'h2D36, sc, 8'h00);
    store_request = 1'b0;
    @(negedge clk);
    chk(seen, 6'h08);
  endtask
  task t_tune;
    for (i = 0; i < 8; i = i + 1)
    begin
      seen = 6'h00;
      @(negedge clk);
      tune_progress = 8'h10 + i;
      xfer(1, 16'h2D50, i % 3 + 1, 8'h00);
      xfer(0, 16'h2D50, i % 3 + 1, 8'h00);
      xfer(0, 16'h2D51, 8'h10 + i, 8'h00);
      pulse_done(i == 0 ? 16'h0 : (i == 7 ? 16'hC00F : 16'hBFFF + i));
      xfer(0, 16'h2D50, 32'h0, 8'h00);
      xfer(0, 16'h2D51, 32'h64, 8'h00);
      xfer(0, 16'h2D54, tune_result, 8'h00);
      chk(seen, 6'h10);
    end
  endtask
  task t_stop;
    xfer(1, 16'h2D50, 32'h2, 8'h00);
    xfer(1, 16'h2D50, 32'h1, 8'h0C);
    xfer(1, 16'h2D50, 32'h4, 8'h09);
    xfer(1, 16'h2D52, 32'h1234, 8'h09);
    seen = 6'h00;
    xfer(1, 16'h2D52, 32'h1EA5, 8'h00);
    @(negedge clk);
    chk(seen, 6'h01);
    pulse_done(16'hC000);
    xfer(0, 16'h2D54, 32'hC000, 8'h00);
    xfer(0, 16'h2D51, 32'h64, 8'h00);
    // stop by writing mode zero
    seen = 6'h00;
    xfer(1, 16'h2D50, 32'h3, 8'h00);
    xfer(1, 16'h2D50, 32'h0, 8'h00);
    @(negedge clk);
    chk(seen, 6'h11);
    pulse_done(16'hC000);
    xfer(0, 16'h2D50, 32'h0, 8'h00);
  endtask
  task t_clear;
    seen = 4'h0;
    xfer(1, 16'h2D53, 32'h0, 8'h00);
    repeat (2) @(negedge clk);
    chk(seen, 4'hA);
    seen = 4'h0;
    xfer(1, 16'h2D53, 32'h1, 8'h00);
    repeat (2) @(negedge clk);
    chk(seen, 4'hC);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    {rst_n, io_run_mode, net_wait_connect, tune_done, store_request, seen} = 11'h000;
    {tune_progress, tune_result, sc} = {8'h00, 16'h0000, 32'h8000003F};
    {mismatches, checked} = {32'd0, 32'd0};
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_apply;
    t_state;
    t_scale;
    t_tune;
    t_stop;
    t_clear;
    report_and_stop(0);
  end
endmodule // param_enable_and_autotune_objects_tb_top
